//--- core/rtcc_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_regs.svh"

module rtcc_divider
	import rtcc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Selects
	input  wire logic [2:0] src_sel,
	input  wire logic [1:0] out_sel,
	input  wire logic       out_en,
	// Results
	output logic            src_tick,
	output logic            clk_div
);

	logic [12:0] cnt;
	logic [12:0] ones;
	logic        next_div;

	// ==========================================================
	// Prescaler, free running so selects can change any time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cnt <= 13'h0000;
		else
			cnt <= cnt + 13'h0001;
	end

	// Low bits all ones marks the last cycle of each period
	genvar i;
	generate
		for (i = 0; i < 13; i++) begin : g_ones
			assign ones[i] = &cnt[i:0];
		end
	endgenerate

	// Divide by 8,32,128,256,512,2048,4096,8192
	assign src_tick = (src_sel == 3'h0) ? ones[2]  :
	                  (src_sel == 3'h1) ? ones[4]  :
	                  (src_sel == 3'h2) ? ones[6]  :
	                  (src_sel == 3'h3) ? ones[7]  :
	                  (src_sel == 3'h4) ? ones[8]  :
	                  (src_sel == 3'h5) ? ones[10] :
	                  (src_sel == 3'h6) ? ones[11] : ones[12];

	// Divide by 4, 8, 16; code 11 gives a quiet low
	assign next_div = out_en & ((out_sel == 2'h0) ? cnt[1] :
	                            (out_sel == 2'h1) ? cnt[2] :
	                            (out_sel == 2'h2) ? cnt[3] : 1'b0);

	// Registered so the pin never glitches on a select change
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			clk_div <= 1'b0;
		else
			clk_div <= next_div;
	end

endmodule
`default_nettype wire

//--- core/rtcc_pkg.sv
package rtcc_pkg;
	// Update sequencer states
	typedef enum logic {
		RTCC_IDLE,
		RTCC_BUSY
	} rtcc_state_t;
endpackage

//--- core/rtcc_regs.svh
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RTCC_OFF_CTRL1   8'h00
`define RTCC_OFF_CTRL2   8'h04
`define RTCC_OFF_CSR     8'h08
`define RTCC_OFF_SEC     8'h0C
`define RTCC_OFF_MIN     8'h10
`define RTCC_OFF_HOUR    8'h14
`define RTCC_OFF_WEEK    8'h18
`define RTCC_OFF_FLAG    8'h1C

// ==========================================================
// Field positions
`define RTCC_C1_RUN      7
`define RTCC_C1_MODE24   6
`define RTCC_C1_PM       5
`define RTCC_C1_SRST     4
`define RTCC_C1_INTAFT   3
`define RTCC_C2_OVF      5
`define RTCC_BUSY_BIT    7
`define RTCC_FLAG_BIT    0
`define RTCC_CS_TK       3

// ==========================================================
// Readable masks and reset values
`define RTCC_C1_MASK     8'hF8
`define RTCC_C2_MASK     8'h3F
`define RTCC_CS_MASK     8'h6F
`define RTCC_C1_RST      8'h00
`define RTCC_C2_RST      8'h00
`define RTCC_CS_RST      8'h08

// ==========================================================
// Time limits
`define RTCC_SEC_MAX     6'h3B
`define RTCC_MIN_MAX     6'h3B
`define RTCC_HR24_MAX    5'h17
`define RTCC_HR12_MAX    5'h0B
`define RTCC_WK_MAX      3'h6
`define RTCC_FRC_MAX     8'hFF

// ==========================================================
// Timing
`define RTCC_CLK_MHZ     20
`define RTCC_SECOND_US   1000000
`define RTCC_BUSY_US     62500

`endif

//--- core/rtcc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_regs.svh"

module rtcc_top
	import rtcc_pkg::*;
#(
	parameter int SEC_CYCLES  = `RTCC_SECOND_US * `RTCC_CLK_MHZ,
	parameter int BUSY_CYCLES = `RTCC_BUSY_US * `RTCC_CLK_MHZ
)(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Chip state and port mode
	input  wire logic        PORT_MODE_CLKOUT,
	input  wire logic        CHIP_ACTIVE,
	// Pins and status
	output logic             CLOCK_OUTPUT_PIN,
	output logic             UPDATE_IN_PROGRESS,
	output logic             TIMER_EVENT_FLAG
);

	// ==========================================================
	// Declarations
	logic [7:0]  ctrl1;
	logic [7:0]  ctrl2;
	logic [7:0]  csr;
	logic [5:0]  sec;
	logic [5:0]  min;
	logic [4:0]  hr;
	logic [2:0]  wk;
	logic [7:0]  frc;
	logic [24:0] sec_cnt;
	logic [24:0] busy_cnt;
	rtcc_state_t state;
	logic        flag;
	logic [7:0]  rd_reg;

	// ==========================================================
	// APB decode
	wire setup    = PSEL & ~PENABLE;
	wire wr       = PSEL & PENABLE & PWRITE;
	wire [7:0] wd = PWDATA[7:0];
	wire hit_c1   = (PADDR == `RTCC_OFF_CTRL1);
	wire hit_c2   = (PADDR == `RTCC_OFF_CTRL2);
	wire hit_cs   = (PADDR == `RTCC_OFF_CSR);
	wire hit_sec  = (PADDR == `RTCC_OFF_SEC);
	wire hit_min  = (PADDR == `RTCC_OFF_MIN);
	wire hit_hr   = (PADDR == `RTCC_OFF_HOUR);
	wire hit_wk   = (PADDR == `RTCC_OFF_WEEK);
	wire hit_flag = (PADDR == `RTCC_OFF_FLAG);
	wire mapped   = hit_c1 | hit_c2 | hit_cs | hit_sec | hit_min |
	                hit_hr | hit_wk | hit_flag;

	// Zero wait state; unmapped addresses answer with an error
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	// ==========================================================
	// Control fields
	wire run       = ctrl1[`RTCC_C1_RUN];
	wire mode24    = ctrl1[`RTCC_C1_MODE24];
	wire pm        = ctrl1[`RTCC_C1_PM];
	wire srst      = ctrl1[`RTCC_C1_SRST];
	wire int_after = ctrl1[`RTCC_C1_INTAFT];
	wire tk_mode   = csr[`RTCC_CS_TK];
	wire tk_run    = run & tk_mode & ~srst;
	wire fr_run    = run & ~tk_mode & ~srst;
	wire busy      = (state == RTCC_BUSY);

	// ==========================================================
	// Divider for counter source and clock output
	wire src_tick;
	wire clk_div;

	rtcc_divider rtcc_divider_inst (
		.clk      (CLK),
		.rstn     (RSTN),
		.src_sel  (csr[2:0]),
		.out_sel  (csr[6:5]),
		.out_en   (PORT_MODE_CLKOUT & CHIP_ACTIVE),
		.src_tick (src_tick),
		.clk_div  (clk_div)
	);

	assign CLOCK_OUTPUT_PIN = clk_div;

	// ==========================================================
	// Carry chain, evaluated on the values about to be stepped
	wire [4:0] hr_top  = mode24 ? `RTCC_HR24_MAX : `RTCC_HR12_MAX;
	wire sec_wrap      = (sec == `RTCC_SEC_MAX);
	wire min_wrap      = sec_wrap & (min == `RTCC_MIN_MAX);
	wire hr_wrap       = min_wrap & (hr == hr_top);
	wire day_roll      = hr_wrap & (mode24 | pm);
	wire wk_wrap       = day_roll & (wk == `RTCC_WK_MAX);

	// ==========================================================
	// Update sequencer timing
	wire sec_tick  = tk_run & (state == RTCC_IDLE) &
	                 (sec_cnt == 25'(SEC_CYCLES - 1));
	wire busy_done = busy & (busy_cnt == 25'(BUSY_CYCLES - 1));
	wire frc_tick  = fr_run & src_tick;
	wire frc_ovf   = frc_tick & (frc == `RTCC_FRC_MAX);

	// Periodic events at busy start or at busy end
	wire periodic  = int_after ? busy_done : sec_tick;

	// ==========================================================
	// Event vector in control-two bit order
	wire [5:0] events = {
		frc_ovf & ~tk_mode,
		periodic & wk_wrap,
		periodic & day_roll,
		periodic & min_wrap,
		periodic & sec_wrap,
		periodic
	};
	wire event_hit = |(events & ctrl2[5:0]);

	wire flag_clr  = wr & hit_flag & ~wd[`RTCC_FLAG_BIT];

	// Set beats a clear arriving in the same cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			flag <= 1'b0;
		else if (event_hit)
			flag <= 1'b1;
		else if (flag_clr)
			flag <= 1'b0;
	end

	assign TIMER_EVENT_FLAG = flag;

	// ==========================================================
	// Control register one; hardware flips the afternoon flag
	wire pm_flip = busy_done & hr_wrap & ~mode24;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			ctrl1 <= `RTCC_C1_RST;
		else if (wr & hit_c1)
			ctrl1 <= wd & `RTCC_C1_MASK;
		else if (srst)
			ctrl1 <= ctrl1 & (8'h01 << `RTCC_C1_SRST);
		else if (pm_flip)
			ctrl1[`RTCC_C1_PM] <= ~pm;
	end

	// Control register two
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			ctrl2 <= `RTCC_C2_RST;
		else if (wr & hit_c2)
			ctrl2 <= wd & `RTCC_C2_MASK;
		else if (srst)
			ctrl2 <= `RTCC_C2_RST;
	end

	// Source select: soft reset leaves it alone
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			csr <= `RTCC_CS_RST;
		else if (wr & hit_cs)
			csr <= wd & `RTCC_CS_MASK;
	end

	// ==========================================================
	// Update sequencer: one second, then busy, then new time
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state    <= RTCC_IDLE;
			sec_cnt  <= 25'h0000000;
			busy_cnt <= 25'h0000000;
		end else if (srst | ~tk_mode) begin
			state    <= RTCC_IDLE;
			sec_cnt  <= 25'h0000000;
			busy_cnt <= 25'h0000000;
		end else begin
			unique case (state)
				RTCC_IDLE: begin
					busy_cnt <= 25'h0000000;
					if (sec_tick) begin
						sec_cnt <= 25'h0000000;
						state   <= RTCC_BUSY;
					end else if (tk_run) begin
						sec_cnt <= sec_cnt + 25'h0000001;
					end
				end
				RTCC_BUSY: begin
					sec_cnt  <= sec_cnt + 25'h0000001;
					busy_cnt <= busy_cnt + 25'h0000001;
					if (busy_done)
						state <= RTCC_IDLE;
				end
			endcase
		end
	end

	assign UPDATE_IN_PROGRESS = busy;

	// ==========================================================
	// Time registers: no async reset so they survive RSTN
	wire [5:0] next_sec = sec_wrap ? 6'h00 : sec + 6'h01;
	wire [5:0] next_min = min_wrap ? 6'h00 : min + 6'h01;
	wire [4:0] next_hr  = hr_wrap  ? 5'h00 : hr + 5'h01;
	wire [2:0] next_wk  = wk_wrap  ? 3'h0  : wk + 3'h1;

	always_ff @(posedge CLK) begin
		if (srst) begin
			sec <= 6'h00;
			min <= 6'h00;
			hr  <= 5'h00;
			wk  <= 3'h0;
		end else if (wr & (hit_sec | hit_min | hit_hr | hit_wk)) begin
			if (hit_sec)
				sec <= wd[5:0];
			if (hit_min)
				min <= wd[5:0];
			if (hit_hr)
				hr  <= wd[4:0];
			if (hit_wk)
				wk  <= wd[2:0];
		end else if (busy_done) begin
			sec <= next_sec;
			if (sec_wrap)
				min <= next_min;
			if (min_wrap)
				hr  <= next_hr;
			if (day_roll)
				wk  <= next_wk;
		end
	end

	// ==========================================================
	// Free-running counter
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			frc <= 8'h00;
		else if (srst)
			frc <= 8'h00;
		else if (frc_tick)
			frc <= frc + 8'h01;
	end

	// ==========================================================
	// Read data, captured in the setup phase
	wire [7:0] busy_msb = {busy, 7'h00};
	wire [7:0] rd_sec = tk_mode ? (busy_msb | {2'h0, sec}) : frc;
	wire [7:0] rd_mux =
		hit_c1   ? (ctrl1 & `RTCC_C1_MASK) :
		hit_c2   ? (ctrl2 & `RTCC_C2_MASK) :
		hit_cs   ? (csr & `RTCC_CS_MASK) :
		hit_sec  ? rd_sec :
		hit_min  ? (busy_msb | {2'h0, min}) :
		hit_hr   ? (busy_msb | {3'h0, hr}) :
		hit_wk   ? (busy_msb | {5'h00, wk}) :
		hit_flag ? (busy_msb | {7'h00, flag}) : 8'h00;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			rd_reg <= 8'h00;
		else if (setup & ~PWRITE)
			rd_reg <= rd_mux;
	end

	assign PRDATA = {24'h000000, rd_reg};

endmodule
`default_nettype wire

//--- test/rtcc_properties.sv
`timescale 1ns/10ps
`default_nettype none

module rtcc_properties #(
	parameter int SEC_CYCLES  = 40,
	parameter int BUSY_CYCLES = 10
)(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RSTN,
	// APB slave side
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Chip state and pins
	input wire logic        PORT_MODE_CLKOUT,
	input wire logic        CHIP_ACTIVE,
	input wire logic        CLOCK_OUTPUT_PIN,
	input wire logic        UPDATE_IN_PROGRESS,
	input wire logic        TIMER_EVENT_FLAG
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);

	// Access decodes
	logic acc;
	logic rd;
	logic clr;
	int   busy_run;
	assign acc = PSEL && PENABLE;
	assign rd  = acc && !PWRITE;
	assign clr = acc && PWRITE && PADDR == 8'h1C && !PWDATA[0];

	// Busy length so far; a stuck busy shows up here
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			busy_run <= 0;
		else
			busy_run <= UPDATE_IN_PROGRESS ? busy_run + 1 : 0;
	end

	AST_READY:
		assert property (acc |-> PREADY) else $error("no ready");
	AST_HIGH_ZERO:
		assert property (rd |-> PRDATA[31:8] == 24'h0) else $error("high bits");
	AST_C1_RSV:
		assert property (rd && PADDR == 8'h00 |-> PRDATA[2:0] == 3'h0)
		else $error("ctrl1 reserved");
	AST_C2_RSV:
		assert property (rd && PADDR == 8'h04 |-> PRDATA[7:6] == 2'h0)
		else $error("ctrl2 reserved");
	AST_CS_RSV:
		assert property (rd && PADDR == 8'h08 |-> !PRDATA[7] && !PRDATA[4])
		else $error("csr reserved");
	AST_SLVERR:
		assert property (acc && (PADDR > 8'h1C || PADDR[1:0] != 2'h0)
			|-> PSLVERR) else $error("no slverr");
	AST_ACTIVE_GATE:
		assert property (!CHIP_ACTIVE |=> !CLOCK_OUTPUT_PIN)
		else $error("clock out while inactive");
	AST_PORT_GATE:
		assert property (!PORT_MODE_CLKOUT |=> !CLOCK_OUTPUT_PIN)
		else $error("clock out without port mode");
	AST_BUSY_LEN:
		assert property (UPDATE_IN_PROGRESS |-> busy_run < BUSY_CYCLES)
		else $error("busy too long");
	AST_FLAG_HOLD:
		assert property (TIMER_EVENT_FLAG && !clr |=> TIMER_EVENT_FLAG)
		else $error("flag dropped");
	AST_FLAG_CLEAR:
		assert property (clr |=> !TIMER_EVENT_FLAG
			|| $changed(UPDATE_IN_PROGRESS)) else $error("flag kept");
endmodule

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic        clk, rstn, psel, penable, pwrite, pm, act;
	logic        pready, pslverr, pin, busy, flag, re;
	logic [7:0]  paddr, v0;
	logic [31:0] pwdata, prdata, rv;
	int          bad_count, checks_done, n;
	int          dv[8] = '{8, 32, 128, 256, 512, 2048, 4096, 8192};
	int          ne[4] = '{16, 8, 4, 0};

	rtcc_top #(.SEC_CYCLES(40), .BUSY_CYCLES(10)) rtcc_top_inst (
		.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PORT_MODE_CLKOUT(pm), .CHIP_ACTIVE(act),
		.CLOCK_OUTPUT_PIN(pin), .UPDATE_IN_PROGRESS(busy),
		.TIMER_EVENT_FLAG(flag));

	// Clock
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task stall;
		bad_count++;
		$display("unexpected wait ran out");
		tally_and_finish;
	endtask

	// One APB transfer; request held until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [7:0] dat);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, dat};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) stall;
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(nm, rv, e);
	endtask

	// Busy level wait, sampled mid-cycle to stay clear of edge races
	task wb(input logic lvl);
		int k;
		for (k = 0; k < 300; k++) begin
			@(negedge clk);
			if (busy === lvl) break;
		end
		if (k == 300) stall;
	endtask

	task fl(input logic e);
		@(negedge clk);
		chk("event flag", flag, e);
	endtask

	// Rising edges of the output pin over 64 cycles
	task cr(input int e);
		int   r;
		logic p;
		r = 0;
		@(negedge clk);
		p = pin;
		repeat (64) begin
			@(negedge clk);
			if (pin && !p) r++;
			p = pin;
		end
		chk("clock out", e == 0 ? r == 0 : r >= e - 1 && r <= e + 1, 1);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rstn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		pm = 1;
		act = 1;
		bad_count = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rc("ctrl1 reset", 8'h00, 32'h00);
		rc("ctrl2 reset", 8'h04, 32'h00);
		rc("csr reset", 8'h08, 32'h08);
		apb(1, 8'h00, 8'hEF);
		rc("ctrl1 mask", 8'h00, 32'hE8);
		apb(1, 8'h00, 8'h00);
		apb(1, 8'h04, 8'hC1);
		rc("ctrl2 mask", 8'h04, 32'h01);
		apb(1, 8'h08, 8'hFF);
		rc("csr mask", 8'h08, 32'h6F);
		apb(0, 8'h20, 8'h00);
		chk("unmapped error", re, 1);
		chk("unmapped data", rv, 0);
		// Soft reset spares the source select
		apb(1, 8'h08, 8'h28);
		apb(1, 8'h00, 8'h10);
		rc("ctrl2 soft", 8'h04, 32'h00);
		rc("csr soft", 8'h08, 32'h28);
		rc("ctrl1 soft", 8'h00, 32'h10);
		apb(1, 8'h00, 8'h00);
		// Full rollover at 11:59:59 p.m. on the last weekday
		apb(1, 8'h0C, 8'h3B);
		apb(1, 8'h10, 8'h3B);
		apb(1, 8'h14, 8'h0B);
		apb(1, 8'h18, 8'h06);
		apb(1, 8'h04, 8'h10);
		apb(1, 8'h00, 8'hA0);
		wb(1);
		chk("flag at busy start", flag, 1);
		wb(0);
		rc("sec", 8'h0C, 32'h00);
		rc("min", 8'h10, 32'h00);
		rc("hour", 8'h14, 32'h00);
		rc("week", 8'h18, 32'h00);
		rc("afternoon", 8'h00, 32'h80);
		apb(1, 8'h04, 8'h00);
		apb(1, 8'h1C, 8'h00);
		fl(0);
		// 24-hour mode, event after busy
		apb(1, 8'h00, 8'h00);
		apb(1, 8'h0C, 8'h3B);
		apb(1, 8'h10, 8'h3B);
		apb(1, 8'h14, 8'h0B);
		apb(1, 8'h04, 8'h04);
		apb(1, 8'h00, 8'hC8);
		wb(1);
		fl(0);
		wb(0);
		fl(1);
		rc("hour 24", 8'h14, 32'h0C);
		apb(1, 8'h04, 8'h00);
		apb(1, 8'h1C, 8'h00);
		fl(0);
		// Minute event comes from a seconds carry alone
		apb(1, 8'h0C, 8'h3B);
		apb(1, 8'h04, 8'h02);
		wb(1);
		wb(0);
		fl(1);
		rc("minute carry", 8'h10, 32'h01);
		apb(1, 8'h04, 8'h00);
		apb(1, 8'h1C, 8'h00);
		fl(0);
		// Stopped time, then a system reset
		apb(1, 8'h00, 8'h00);
		apb(1, 8'h0C, 8'h15);
		repeat (100) @(posedge clk);
		rc("sec stopped", 8'h0C, 32'h15);
		chk("busy stopped", busy, 0);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rc("sec kept", 8'h0C, 32'h15);
		rc("hour kept", 8'h14, 32'h0C);
		// Free-running counter on every source code
		for (n = 0; n < 8; n++) begin
			apb(1, 8'h08, n[7:0]);
			apb(0, 8'h0C, 8'h00);
			v0 = rv[7:0];
			apb(1, 8'h00, 8'h80);
			repeat (2 * dv[n]) @(posedge clk);
			apb(1, 8'h00, 8'h00);
			apb(0, 8'h0C, 8'h00);
			v0 = rv[7:0] - v0;
			chk("count step", v0 >= 2 && v0 <= 3, 1);
			rc("count held", 8'h0C, rv);
		end
		chk("no busy as counter", busy, 0);
		// Overflow event
		apb(1, 8'h00, 8'h10);
		apb(1, 8'h00, 8'h00);
		apb(1, 8'h08, 8'h00);
		apb(1, 8'h04, 8'h20);
		apb(1, 8'h00, 8'h80);
		for (n = 0; n < 2200 && flag !== 1'b1; n++) @(negedge clk);
		if (n == 2200) stall;
		chk("overflow flag", flag, 1);
		chk("overflow time", n >= 2030 && n <= 2060, 1);
		// Divided clock output and its gates
		apb(1, 8'h00, 8'h00);
		apb(1, 8'h04, 8'h00);
		apb(1, 8'h1C, 8'h00);
		for (n = 0; n < 4; n++) begin
			apb(1, 8'h08, {1'b0, n[1:0], 5'h08});
			cr(ne[n]);
		end
		apb(1, 8'h08, 8'h08);
		@(posedge clk);
		act <= 1'b0;
		cr(0);
		@(posedge clk);
		act <= 1'b1;
		pm <= 1'b0;
		cr(0);
		tally_and_finish;
	end
endmodule

bind rtcc_top rtcc_properties #(
	.SEC_CYCLES(SEC_CYCLES), .BUSY_CYCLES(BUSY_CYCLES)
) rtcc_properties_inst (
	.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR),
	.PORT_MODE_CLKOUT(PORT_MODE_CLKOUT), .CHIP_ACTIVE(CHIP_ACTIVE),
	.CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN),
	.UPDATE_IN_PROGRESS(UPDATE_IN_PROGRESS),
	.TIMER_EVENT_FLAG(TIMER_EVENT_FLAG));

`default_nettype wire
